/* File: adc_sequencer_control.sv */
// control logic of a 10-bit successive approximation converter with 16
// multiplexed channels, an AXI4-Lite register slave and one interrupt.
// assumes an external sample and hold, a 10-bit DAC and a comparator whose
// output is asynchronous; one base_clock_phase equals one sys_clk cycle.
//
// Behaviour
// - 10-bit results from one of 16 channels, sampled through sample and hold.
// - overrun interrupt when a result completes over an unread earlier one.
// - with protection selected, next conversion waits until result is read.
// - unused channel inputs readable by software as digital inputs.
// - single-channel one-shot converts the chosen channel once into result register.
// - single-channel continuous converts the chosen channel back to back.
// - scan one-shot converts each channel from the chosen one down to 0 once, result after each conversion.
// - scan continuous cycles through the channels without stopping.
// - wait-for-read in continuous parks new value and pauses until read.
// - injected conversion during continuous mode goes to the injection register.
// - after injection, the continuous mode carries on unchanged.
// - conversion lasts 14 conversion clocks, 2 sample clocks, 4 base phases.
// - full calibration after reset, at least 1.6 ms, busy flag set throughout.
// - conversions allowed during calibration, which is lengthened by their time.
// - one four-conversion-clock calibration cycle follows every conversion.
// - conversion clock 24, 96 or 48 base phases; code 01 not to be used.
// - sample clock is 1, 2, 4 or 8 conversion clock periods.
`include "adc_seq_map.svh"
`timescale 1ns/10ps
module adc_sequencer_control #(
  parameter int CAL_CYCLES = `ADC_CAL_CYCLES
) (
  // clock, reset, clock enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end
  input wire logic [15:0] ain_digital,
  input wire logic cmp_in,
  output adc_seq_pkg::chan_t chan_sel,
  output logic sample_en,
  output logic [9:0] dac_code,
  // interrupt
  output logic irq
);
  import adc_seq_pkg::*;

  localparam logic [16:0] CAL_LOAD = 17'(CAL_CYCLES - 1);

  seq_state_t state;
  logic [11:0] phase_cnt;
  logic [9:0] sar;
  logic [9:0] bitmask;
  logic [9:0] sar_next;
  chan_t cur_chan;
  logic inj_active;
  logic [31:0] ctrl;
  result_word_t result;
  result_word_t inj_result;
  result_word_t temp_buf;
  logic pending;
  logic parked;
  logic cal_active;
  logic [16:0] cal_cnt;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] ev;
  logic [3:0] next_irq_stat;
  logic cmp_m, cmp_s;
  logic [15:0] din_m, din_s;
  logic cc_tick;
  // bus state
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_full, w_full;
  logic wr_go;
  logic [31:0] wr_val;
  logic rd_result;
  // decoded control fields
  logic cont, scan, wfr, protect, run, inj_req;
  chan_t base_chan, inj_chan;
  logic [7:0] cc_len;
  logic [10:0] sc_len;
  logic [11:0] sample_len, convert_len, recal_len;
  logic xfer_end, conv_main, must_hold, load_direct, park_now, unpark;
  logic inj_go, start_ok, run_clr, start_wr;

  assign cont = ctrl[`CTRL_MODE_LO];
  assign scan = ctrl[`CTRL_MODE_LO + 1];
  assign run = ctrl[`CTRL_RUN];
  assign wfr = ctrl[`CTRL_WFR];
  assign protect = ctrl[`CTRL_PROTECT];
  assign inj_req = ctrl[`CTRL_INJ_REQ];
  assign base_chan = ctrl[`CTRL_CHAN_LO +: 4];
  assign inj_chan = ctrl[`CTRL_INJ_CHAN_LO +: 4];

  // conversion clock length; reserved code 01 falls back to the fastest
  always_comb begin
    case (ctrl[`CTRL_CCS_LO +: 2])
      2'b10: cc_len = 8'(`ADC_CC_TCL_10 * `ADC_TCL_CYCLES);
      2'b11: cc_len = 8'(`ADC_CC_TCL_11 * `ADC_TCL_CYCLES);
      default: cc_len = 8'(`ADC_CC_TCL_00 * `ADC_TCL_CYCLES);
    endcase
  end

  // phase lengths in sys_clk cycles
  assign sc_len = {3'h0, cc_len} << ctrl[`CTRL_SCS_LO +: 2];
  assign sample_len = {sc_len, 1'b0};
  assign convert_len = {4'h0, cc_len} * `ADC_CONV_CC;
  assign recal_len = {4'h0, cc_len} * `ADC_RECAL_CC;

  // successive approximation step: keep or drop the trial bit, try the next
  assign sar_next = (sar & ~bitmask) | (cmp_s ? bitmask : 10'h000) | (bitmask >> 1);

  // result hand-off decisions at the end of the transfer phase
  assign xfer_end = (state == S_TRANSFER) && (phase_cnt == 12'h000);
  assign conv_main = xfer_end && !inj_active;
  assign must_hold = pending && (protect || (wfr && cont));
  assign load_direct = conv_main && !must_hold;
  assign park_now = conv_main && must_hold;
  assign unpark = parked && !pending;
  assign inj_go = inj_req && run && cont;
  assign start_ok = !parked && !(protect && pending) && (run || inj_go);
  assign run_clr = conv_main && !cont && (!scan || cur_chan == 4'h0);

  // two-stage synchronisers for comparator and digital channel inputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmp_m <= 1'b0;
      cmp_s <= 1'b0;
      din_m <= 16'h0000;
      din_s <= 16'h0000;
    end else if (ce) begin
      cmp_m <= cmp_in;
      cmp_s <= cmp_m;
      din_m <= ain_digital;
      din_s <= din_m;
    end
  end

  // conversion clock ticks aligned to the start of the convert phase
  period_ticker period_ticker_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .restart(state == S_SAMPLE && phase_cnt == 12'h000),
    .period(cc_len),
    .tick(cc_tick)
  );

  // conversion sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      phase_cnt <= 12'h000;
      sar <= 10'h000;
      bitmask <= 10'h000;
      cur_chan <= 4'h0;
      inj_active <= 1'b0;
      chan_sel <= 4'h0;
      sample_en <= 1'b0;
      dac_code <= 10'h000;
    end else if (ce) begin
      case (state)
        S_IDLE: begin
          if (start_ok) begin
            if (inj_go) begin
              inj_active <= 1'b1;
              chan_sel <= inj_chan;
            end else begin
              chan_sel <= cur_chan;
            end
            sample_en <= 1'b1;
            phase_cnt <= sample_len - 12'h001;
            state <= S_SAMPLE;
          end
        end
        S_SAMPLE: begin
          if (phase_cnt == 12'h000) begin
            sample_en <= 1'b0;
            sar <= `ADC_SAR_FIRST;
            bitmask <= `ADC_SAR_FIRST;
            dac_code <= `ADC_SAR_FIRST;
            phase_cnt <= convert_len - 12'h001;
            state <= S_CONVERT;
          end else begin
            phase_cnt <= phase_cnt - 12'h001;
          end
        end
        S_CONVERT: begin
          // ten bit decisions, the remaining conversion clocks settle
          if (cc_tick && bitmask != 10'h000) begin
            sar <= sar_next;
            dac_code <= sar_next;
            bitmask <= bitmask >> 1;
          end
          if (phase_cnt == 12'h000) begin
            phase_cnt <= 12'(`ADC_XFER_TCL * `ADC_TCL_CYCLES) - 12'h001;
            state <= S_TRANSFER;
          end else begin
            phase_cnt <= phase_cnt - 12'h001;
          end
        end
        S_TRANSFER: begin
          if (phase_cnt == 12'h000) begin
            inj_active <= 1'b0;
            if (!inj_active && scan) begin
              // scan walks down from the chosen channel to channel 0
              cur_chan <= (cur_chan == 4'h0) ? base_chan : cur_chan - 4'h1;
            end
            phase_cnt <= recal_len - 12'h001;
            state <= S_RECAL;
          end else begin
            phase_cnt <= phase_cnt - 12'h001;
          end
        end
        S_RECAL: begin
          if (phase_cnt == 12'h000) begin
            state <= S_IDLE;
          end else begin
            phase_cnt <= phase_cnt - 12'h001;
          end
        end
        default: state <= S_IDLE;
      endcase
      // a fresh start reloads the channel; it wins over the scan step
      if (start_wr) begin
        cur_chan <= wr_val[`CTRL_CHAN_LO +: 4];
      end
    end
  end

  // result registers, pending flag and the wait-for-read buffer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result <= 16'h0000;
      inj_result <= 16'h0000;
      temp_buf <= 16'h0000;
      pending <= 1'b0;
      parked <= 1'b0;
    end else if (ce) begin
      if (rd_result) begin
        pending <= 1'b0;
      end
      if (load_direct) begin
        result <= {chan_sel, 2'h0, sar};
        pending <= 1'b1;
      end else if (unpark) begin
        result <= temp_buf;
        pending <= 1'b1;
        parked <= 1'b0;
      end
      if (park_now) begin
        temp_buf <= {chan_sel, 2'h0, sar};
        parked <= 1'b1;
      end
      if (xfer_end && inj_active) begin
        inj_result <= {chan_sel, 2'h0, sar};
      end
    end
  end

  // reset calibration; it pauses while a conversion runs, so it stretches
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cal_active <= 1'b1;
      cal_cnt <= CAL_LOAD;
    end else if (ce) begin
      if (cal_active && state == S_IDLE) begin
        if (cal_cnt == 17'h00000) begin
          cal_active <= 1'b0;
        end else begin
          cal_cnt <= cal_cnt - 17'h00001;
        end
      end
    end
  end

  // events for the sticky status bits
  always_comb begin
    ev = 4'h0;
    ev[`EV_CONV_DONE] = load_direct || unpark;
    ev[`EV_OVERRUN] = load_direct && pending && !protect;
    ev[`EV_INJ_DONE] = xfer_end && inj_active;
    ev[`EV_CAL_DONE] = cal_active && state == S_IDLE && cal_cnt == 17'h00000;
  end

  // write data merged with byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  assign wr_go = aw_full && w_full && !s_axi_bvalid;
  assign wr_val = merge(ctrl, w_data, w_strb) & `CTRL_WMASK;
  // only a write that starts a stopped converter reloads the channel, so an
  // injection request written while running leaves the scan position alone
  assign start_wr = wr_go && aw_addr == `OFS_CTRL && w_strb[0] && w_data[`CTRL_RUN] && !run;
  assign rd_result = s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'b00} == `OFS_RESULT;

  // control register; hardware clears run when done and the injection request when it starts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RESET;
    end else if (ce) begin
      if (run_clr) begin
        ctrl[`CTRL_RUN] <= 1'b0;
      end
      if (state == S_IDLE && start_ok && inj_go) begin
        ctrl[`CTRL_INJ_REQ] <= 1'b0;
      end
      if (wr_go && aw_addr == `OFS_CTRL) begin
        ctrl <= wr_val;
      end
    end
  end

  // sticky status with set winning over write-one-to-clear, and the mask
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_go && aw_addr == `OFS_IRQ_STATUS && w_strb[0]) begin
      next_irq_stat = irq_stat & ~w_data[3:0];
    end
    next_irq_stat = next_irq_stat | ev;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat <= next_irq_stat;
      if (wr_go && aw_addr == `OFS_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[3:0];
      end
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // axi write channels: address and data taken independently, then answered
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        // read-only registers accept writes silently; unmapped gets slverr
        s_axi_bresp <= (aw_addr > `OFS_DIGITAL_IN) ? 2'b10 : 2'b00;
        aw_full <= 1'b0;
        w_full <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read channel with a one-cycle registered answer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case ({s_axi_araddr[7:2], 2'b00})
          `OFS_CTRL: s_axi_rdata <= ctrl;
          `OFS_STATUS: s_axi_rdata <= {24'h000000, cur_chan, parked, pending, cal_active,
                                       cal_active || state != S_IDLE};
          `OFS_RESULT: s_axi_rdata <= {16'h0000, result};
          `OFS_INJ_RESULT: s_axi_rdata <= {16'h0000, inj_result};
          `OFS_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irq_stat};
          `OFS_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask};
          `OFS_DIGITAL_IN: s_axi_rdata <= {16'h0000, din_s};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : adc_sequencer_control

/* File: adc_seq_map.svh */
// register offsets, field positions, reset values and timing counts of the
// converter control block; assumes a 50 MHz sys_clk and byte addresses.
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RESULT 8'h08
`define OFS_INJ_RESULT 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_DIGITAL_IN 8'h18

// converter_control_register fields
`define CTRL_MODE_LO 0
`define CTRL_RUN 2
`define CTRL_WFR 3
`define CTRL_PROTECT 4
`define CTRL_CHAN_LO 8
`define CTRL_CCS_LO 12
`define CTRL_SCS_LO 14
`define CTRL_INJ_REQ 16
`define CTRL_INJ_CHAN_LO 20
`define CTRL_RESET 32'h0000_0000
`define CTRL_WMASK 32'h00f1_ff1f

// interrupt event bits
`define EV_CONV_DONE 0
`define EV_OVERRUN 1
`define EV_INJ_DONE 2
`define EV_CAL_DONE 3

// timing: one base_clock_phase is 20 ns
`define ADC_CLK_NS 20
`define ADC_TCL_NS 20
`define ADC_TCL_CYCLES ((`ADC_TCL_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_CC_TCL_00 8'h18
`define ADC_CC_TCL_10 8'h60
`define ADC_CC_TCL_11 8'h30
`define ADC_CONV_CC 12'h00e
`define ADC_XFER_TCL 12'h004
`define ADC_RECAL_CC 12'h004
`define ADC_SAR_FIRST 10'h200
`define ADC_CAL_TIME_NS 1600000
`define ADC_CAL_CYCLES ((`ADC_CAL_TIME_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`endif

/* File: adc_seq_pkg.sv */
// types shared by the converter control block
package adc_seq_pkg;
  typedef enum logic [2:0] {S_IDLE, S_SAMPLE, S_CONVERT, S_TRANSFER, S_RECAL} seq_state_t;
  typedef logic [15:0] result_word_t;
  typedef logic [3:0] chan_t;
endpackage : adc_seq_pkg

/* File: period_ticker.sv */
// period tick generator for the conversion clock
// assumes period is at least 2 and stays stable while counting
`timescale 1ns/10ps
module period_ticker (
  // clock and control
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic restart,
  // length of one period in cycles
  input wire logic [7:0] period,
  // one-cycle pulse at the end of each period
  output logic tick
);
  logic [7:0] cnt;

  // free count that restarts on request, so ticks align to the phase start
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        cnt <= 8'h00;
        tick <= 1'b0;
      end else if (cnt == period - 8'h01) begin
        cnt <= 8'h00;
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 8'h01;
        tick <= 1'b0;
      end
    end
  end
endmodule : period_ticker

/* File: adc_seq_assertions.sv */
// port checker of the converter control block
// assumes ce held high, so every count is in sys_clk cycles
`timescale 1ns/10ps
module adc_seq_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end
  input wire adc_seq_pkg::chan_t chan_sel,
  input wire logic sample_en,
  input wire logic [9:0] dac_code
);
  import adc_seq_pkg::*;
  logic [15:0] slen, gap, dgap;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // phase counters; gaps start saturated so the first start is not judged
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slen <= 16'h0000;
      gap <= 16'hffff;
      dgap <= 16'hffff;
    end else begin
      slen <= sample_en ? slen + 16'h0001 : 16'h0000;
      gap <= sample_en ? 16'h0000 : gap + {15'h0000, ~&gap};
      dgap <= $changed(dac_code) ? 16'h0000 : dgap + {15'h0000, ~&dgap};
    end
  end
  property p_samp_len;
    $fell(sample_en) |-> slen inside {16'h0030, 16'h0060, 16'h00c0, 16'h0180, 16'h0300, 16'h0600};
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("bad sample length");
  // convert, transfer and recal at the fastest clock take 436 cycles
  property p_conv_gap;
    $rose(sample_en) |-> gap >= 16'h01b4;
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("restart too soon");
  property p_trial_start;
    $fell(sample_en) |-> ##[0:1] dac_code == 10'h200;
  endproperty
  a_trial_start: assert property (p_trial_start) else $error("bad first trial");
  property p_trial_pace;
    $changed(dac_code) |-> dgap >= 16'h0017;
  endproperty
  a_trial_pace: assert property (p_trial_pace) else $error("trial too fast");
  property p_chan_hold;
    sample_en ##1 sample_en |-> $stable(chan_sel);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("late write answer");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
  c_short: cover property ($fell(sample_en) && slen == 16'h0030);
  c_long: cover property ($fell(sample_en) && slen == 16'h00c0);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : adc_seq_assertions

/* File: analog_front_model.sv */
// analog side: channel levels, sample and hold, comparator
// assumes levels stay put while a channel is converted
`timescale 1ns/10ps
module analog_front_model (
  // clock
  input wire logic sys_clk,
  // ten-bit level of each of the sixteen channels
  input wire logic [159:0] levels,
  // converter side
  input wire adc_seq_pkg::chan_t chan_sel,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  output logic cmp_in
);
  import adc_seq_pkg::*;
  logic [9:0] held = 10'h000;
  // hold capacitor tracks the selected channel only while sampling
  always_ff @(posedge sys_clk) begin
    if (sample_en) begin
      held <= levels[chan_sel * 10 +: 10];
    end
  end
  // comparator keeps the trial bit while the held level reaches the code
  assign cmp_in = (held >= dac_code);
endmodule : analog_front_model

/* File: adc_sequencer_control_test.sv */
// self-checking bench of the converter control block over its register bus
// assumes the hand-over register map; a short calibration keeps the run brief
`include "adc_seq_map.svh"
`timescale 1ns/10ps
`define CHECK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("wrong value at %0t: got %h want %h", $time, (g), (e)); \
    end \
  end
module adc_sequencer_control_test;
  import adc_seq_pkg::*;
  typedef struct {
    logic [33:0] val;
    logic [33:0] msk;
  } note_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, c;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] ain_digital = 16'h0000;
  logic cmp_in, sample_en, irq;
  logic [9:0] dac_code;
  chan_t chan_sel;
  logic [159:0] levels = 160'h0;
  logic [31:0] seed = 32'h8026d8bd;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  note_t rq[$];
  logic [1:0] bq[$];
  note_t n;
  logic [1:0] br;

  adc_sequencer_control #(.CAL_CYCLES(50)) adc_sequencer_control_inst (.*);
  analog_front_model analog_front_model_inst (.sys_clk, .levels, .chan_sel, .sample_en,
    .dac_code, .cmp_in);

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic logic [31:0] ctl(input logic [1:0] md, input logic wf, input logic pr,
      input logic [3:0] ch, input logic [1:0] cs, input logic [1:0] ss);
    logic [31:0] v;
    v = `CTRL_RESET;
    v[`CTRL_MODE_LO +: 2] = md;
    v[`CTRL_RUN] = 1'b1;
    v[`CTRL_WFR] = wf;
    v[`CTRL_PROTECT] = pr;
    v[`CTRL_CHAN_LO +: 4] = ch;
    v[`CTRL_CCS_LO +: 2] = cs;
    v[`CTRL_SCS_LO +: 2] = ss;
    return v;
  endfunction : ctl

  // a sampled level comes back exactly, with its channel above it
  function automatic logic [31:0] res(input logic [3:0] ch);
    return {16'h0000, ch, 2'b00, levels[ch * 10 +: 10]};
  endfunction : res

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // one read; the expected word and its mask go to the notes
  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] v,
      input logic [31:0] m);
    note_t t;
    t.val = {r, v & m};
    t.msk = {2'b11, m};
    rq.push_back(t);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // rready follows rvalid by one cycle so the answer must be held
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
    `CHECK(irq, 1'b1)
  endtask : wait_irq

  task automatic conv(input logic [3:0] ch);
    wait_irq(4000);
    rd(`OFS_RESULT, 2'b00, res(ch), 32'h0000_f3ff);
    wr(`OFS_IRQ_STATUS, 32'h1, 2'b00);
  endtask : conv

  // stop, let the last conversion end, drain both result slots
  task automatic flush;
    wr(`OFS_CTRL, 32'h0, 2'b00);
    repeat (2500) @(posedge sys_clk);
    repeat (2) rd(`OFS_RESULT, 2'b00, 32'h0, 32'h0);
    wr(`OFS_IRQ_STATUS, 32'hf, 2'b00);
  endtask : flush

  // compare each bus answer with the oldest note
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      n = rq.pop_front();
      `CHECK({s_axi_rresp, s_axi_rdata} & n.msk, n.val)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      br = bq.pop_front();
      `CHECK(s_axi_bresp, br)
    end
  end

  // a hang ends the run as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      levels[i * 10 +: 10] <= seed[9:0];
    end
    seed = xs(seed);
    ain_digital <= seed[15:0];
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`OFS_CTRL, 2'b00, `CTRL_RESET, 32'hffff_ffff);
    rd(`OFS_IRQ_MASK, 2'b00, 32'h0, 32'hf);
    rd(`OFS_DIGITAL_IN, 2'b00, {16'h0000, ain_digital}, 32'hffff);
    rd(8'h1c, 2'b10, 32'h0, 32'hffff_ffff);
    wr(8'h1c, 32'h0, 2'b10);
    wr(`OFS_IRQ_MASK, 32'h1, 2'b00);
    wr(`OFS_CTRL, ctl(2'b00, 1'b0, 1'b1, 4'h3, 2'b00, 2'b00), 2'b00);
    rd(`OFS_STATUS, 2'b00, 32'h3, 32'h3);
    conv(4'h3);
    rd(`OFS_CTRL, 2'b00, 32'h0, 32'h4);
    repeat (200) @(posedge sys_clk);
    rd(`OFS_STATUS, 2'b00, 32'h0, 32'h2);
    rd(`OFS_IRQ_STATUS, 2'b00, 32'h8, 32'h8);
    wr(`OFS_IRQ_STATUS, 32'hf, 2'b00);
    // scan one-shot counts down from the channel field to zero
    wr(`OFS_CTRL, ctl(2'b10, 1'b0, 1'b1, 4'h1, 2'b00, 2'b00), 2'b00);
    conv(4'h1);
    conv(4'h0);
    rd(`OFS_CTRL, 2'b00, 32'h0, 32'h4);
    // continuous results left unread raise the overrun event, the only one unmasked
    wr(`OFS_IRQ_MASK, 32'h2, 2'b00);
    wr(`OFS_CTRL, ctl(2'b01, 1'b0, 1'b0, 4'h5, 2'b11, 2'b01), 2'b00);
    wait_irq(8000);
    rd(`OFS_RESULT, 2'b00, res(4'h5), 32'h0000_f3ff);
    flush();
    `CHECK(irq, 1'b0)
    // protection, then wait-for-read: nothing new until the result is read
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_IRQ_MASK, 32'h1, 2'b00);
      wr(`OFS_CTRL, ctl(2'b01, i[0], ~i[0], 4'h7, 2'b10, 2'b00), 2'b00);
      wait_irq(4000);
      wr(`OFS_IRQ_STATUS, 32'h1, 2'b00);
      repeat (2500) @(posedge sys_clk);
      `CHECK(irq, 1'b0)
      rd(`OFS_STATUS, 2'b00, {28'h0, i[0], 3'b000}, 32'h8);
      rd(`OFS_RESULT, 2'b00, res(4'h7), 32'h0000_f3ff);
      wait_irq(4000);
      flush();
    end
    // scan continuous with one injected channel in between
    c = ctl(2'b11, 1'b0, 1'b1, 4'h2, 2'b00, 2'b10);
    wr(`OFS_CTRL, c, 2'b00);
    wait_irq(4000);
    wr(`OFS_CTRL, c | (32'h1 << `CTRL_INJ_REQ) | (32'h9 << `CTRL_INJ_CHAN_LO), 2'b00);
    rd(`OFS_RESULT, 2'b00, res(4'h2), 32'h0000_f3ff);
    wr(`OFS_IRQ_STATUS, 32'h1, 2'b00);
    conv(4'h1);
    conv(4'h0);
    conv(4'h2);
    rd(`OFS_INJ_RESULT, 2'b00, res(4'h9), 32'h0000_f3ff);
    rd(`OFS_CTRL, 2'b00, c, 32'h0000_ffff);
    flush();
    report_and_stop();
  end
endmodule : adc_sequencer_control_test

bind adc_sequencer_control adc_seq_assertions adc_seq_assertions_inst (.*);
